//--- itbt_ctrl.sv
// Interrupt-triggered single-channel byte transfer controller
`default_nettype none
module itbt_ctrl (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [7:0]                  reg_rdata,
	input  wire logic [itbt_pkg::NUM_SRC-1:0] src_evt,
	output logic                             bus_req,
	output logic      [15:0]                 mem_addr,
	output logic                             mem_rd,
	output logic                             mem_wr,
	output logic      [7:0]                  mem_wdata,
	input  wire logic [7:0]                  mem_rdata,
	output logic                             cpu_irq,
	output logic      [5:0]                  cpu_irq_src
);
	typedef struct packed {
		itbt_pkg::itbt_state_t    st;
		logic [itbt_pkg::NUM_SRC-1:0] en;
		logic [itbt_pkg::NUM_SRC-1:0] pend;
		logic [5:0]               src;
		logic [4:0]               set;
		logic [3:0]               cnt;
		logic [7:0]               ctl;
		logic [7:0]               bls;
		logic [7:0]               cct;
		logic [7:0]               rld;
		logic [15:0]              sar;
		logic [15:0]              dar;
		logic [8:0]               bcnt;
		logic [7:0]               data;
		logic                     irq_req;
		logic                     stop_req;
		logic                     irq;
		logic [5:0]               irq_src;
		logic [7:0]               rdata;
	} itbt_regs_t;

	itbt_regs_t s;
	itbt_regs_t next_s;

	logic        rpt;
	logic        src_is_area;
	logic        dst_is_area;
	logic [15:0] set_base;

	// Repeat-only bits are masked by the mode bit
	assign rpt = s.ctl[itbt_pkg::CTL_MODE];
	assign src_is_area = rpt && s.ctl[itbt_pkg::CTL_RPT_SEL];
	assign dst_is_area = rpt && !s.ctl[itbt_pkg::CTL_RPT_SEL];
	assign set_base = itbt_pkg::CD_BASE + 16'({s.set, 3'b000});

	// Source index and set number are six and five bits wide; larger sizes would wrap
	if (itbt_pkg::NUM_SRC > 64 || int'(itbt_pkg::LAST_SET) != itbt_pkg::NUM_SETS - 1)
	begin : cfg_check
		$error("package sizes do not fit the index widths");
	end

	// The CPU is held off for the whole activation, chained sets included
	assign bus_req = (s.st != itbt_pkg::ITBT_IDLE);
	assign mem_rd = ((s.st == itbt_pkg::ITBT_LOAD) && (s.cnt < itbt_pkg::CD_BYTES))
		|| (s.st == itbt_pkg::ITBT_XRD);
	assign mem_wr = (s.st == itbt_pkg::ITBT_XWR) || (s.st == itbt_pkg::ITBT_WB);
	assign reg_rdata = s.rdata;
	assign cpu_irq = s.irq;
	assign cpu_irq_src = s.irq_src;

	always_comb
	begin
		unique case (s.st)
			itbt_pkg::ITBT_XRD:  mem_addr = s.sar;
			itbt_pkg::ITBT_XWR:  mem_addr = s.dar;
			default:             mem_addr = set_base + {13'h0000, s.cnt[2:0]};
		endcase
	end

	always_comb
	begin
		unique case (s.cnt[2:0])
			itbt_pkg::FLD_CTL:    mem_wdata = s.ctl;
			itbt_pkg::FLD_BLS:    mem_wdata = s.bls;
			itbt_pkg::FLD_CCT:    mem_wdata = s.cct;
			itbt_pkg::FLD_RLD:    mem_wdata = s.rld;
			itbt_pkg::FLD_SAR_LO: mem_wdata = s.sar[7:0];
			itbt_pkg::FLD_SAR_HI: mem_wdata = s.sar[15:8];
			itbt_pkg::FLD_DAR_LO: mem_wdata = s.dar[7:0];
			itbt_pkg::FLD_DAR_HI: mem_wdata = s.dar[15:8];
		endcase
		if (s.st == itbt_pkg::ITBT_XWR)
			mem_wdata = s.data;
	end

	always_comb
	begin
		logic [5:0]  pick;
		logic        any;
		logic [2:0]  fld;
		logic [15:0] sar_n;
		logic [15:0] dar_n;
		logic        last;
		logic [15:0] area;
		pick = 6'h00;
		any = 1'b0;
		fld = 3'h0;
		sar_n = 16'h0000;
		dar_n = 16'h0000;
		last = 1'b0;
		area = 16'h0000;
		next_s = s;
		next_s.irq = 1'b0;
		next_s.rdata = 8'h00;
		// Lowest numbered pending source is served first
		for (int i = itbt_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (s.pend[i])
			begin
				pick = 6'(i);
				any = 1'b1;
			end
		end
		unique case (s.st)
			itbt_pkg::ITBT_IDLE:
			begin
				if (any)
				begin
					next_s.src = pick;
					// Sources fold onto the sets in turn
					if (pick >= 6'h30)
						next_s.set = 5'(pick - 6'h30);
					else if (pick >= 6'h18)
						next_s.set = 5'(pick - 6'h18);
					else
						next_s.set = pick[4:0];
					next_s.pend[pick] = 1'b0;
					next_s.cnt = 4'h0;
					next_s.irq_req = 1'b0;
					next_s.stop_req = 1'b0;
					next_s.st = itbt_pkg::ITBT_LOAD;
				end
			end
			itbt_pkg::ITBT_LOAD:
			begin
				// Reads are pipelined: field n is captured while n+1 is asked for
				if (s.cnt != 4'h0)
				begin
					fld = 3'(s.cnt - 4'h1);
					unique case (fld)
						itbt_pkg::FLD_CTL:    next_s.ctl = mem_rdata;
						itbt_pkg::FLD_BLS:    next_s.bls = mem_rdata;
						itbt_pkg::FLD_CCT:    next_s.cct = mem_rdata;
						itbt_pkg::FLD_RLD:    next_s.rld = mem_rdata;
						itbt_pkg::FLD_SAR_LO: next_s.sar[7:0] = mem_rdata;
						itbt_pkg::FLD_SAR_HI: next_s.sar[15:8] = mem_rdata;
						itbt_pkg::FLD_DAR_LO: next_s.dar[7:0] = mem_rdata;
						itbt_pkg::FLD_DAR_HI: next_s.dar[15:8] = mem_rdata;
					endcase
				end
				next_s.cnt = s.cnt + 4'h1;
				if (s.cnt == itbt_pkg::CD_BYTES)
				begin
					next_s.cnt = 4'h0;
					next_s.bcnt = (s.bls == 8'h00) ? itbt_pkg::BLOCK_256 : {1'b0, s.bls};
					next_s.st = itbt_pkg::ITBT_XRD;
				end
			end
			itbt_pkg::ITBT_XRD:
				next_s.st = itbt_pkg::ITBT_XCAP;
			itbt_pkg::ITBT_XCAP:
			begin
				next_s.data = mem_rdata;
				next_s.st = itbt_pkg::ITBT_XWR;
			end
			itbt_pkg::ITBT_XWR:
			begin
				// The repeat area always walks; its step bit is ignored
				sar_n = s.sar + {15'h0000, src_is_area || s.ctl[itbt_pkg::CTL_SRC_STEP]};
				dar_n = s.dar + {15'h0000, dst_is_area || s.ctl[itbt_pkg::CTL_DST_STEP]};
				next_s.bcnt = s.bcnt - 9'h001;
				next_s.st = itbt_pkg::ITBT_XRD;
				if (s.bcnt == 9'h001)
				begin
					last = (s.cct == 8'h01);
					next_s.cct = s.cct - 8'h01;
					area = 16'(s.rld * s.bls);
					if (last && rpt)
					begin
						next_s.cct = s.rld;
						if (src_is_area)
							sar_n = sar_n - area;
						else
							dar_n = dar_n - area;
					end
					if (last && (!rpt || s.ctl[itbt_pkg::CTL_RPT_IRQ]))
					begin
						next_s.irq_req = 1'b1;
						next_s.stop_req = 1'b1;
					end
					next_s.cnt = 4'h0;
					next_s.st = itbt_pkg::ITBT_WB;
				end
				next_s.sar = sar_n;
				next_s.dar = dar_n;
			end
			itbt_pkg::ITBT_WB:
			begin
				next_s.cnt = s.cnt + 4'h1;
				if (s.cnt == itbt_pkg::CD_BYTES - 4'h1)
				begin
					next_s.cnt = 4'h0;
					// A chain bit in the last set is a software fault; it is not followed
					if (s.ctl[itbt_pkg::CTL_CHAIN] && (s.set != itbt_pkg::LAST_SET))
					begin
						next_s.set = s.set + 5'h01;
						next_s.st = itbt_pkg::ITBT_LOAD;
					end
					else
						next_s.st = itbt_pkg::ITBT_DONE;
				end
			end
			itbt_pkg::ITBT_DONE:
			begin
				if (s.stop_req)
					next_s.en[s.src] = 1'b0;
				next_s.irq = s.irq_req;
				next_s.irq_src = s.src;
				next_s.st = itbt_pkg::ITBT_IDLE;
			end
			default:
				next_s.st = itbt_pkg::ITBT_IDLE;
		endcase
		// A software write lands after the hardware stop and so wins over it
		for (int r = 0; r < itbt_pkg::NUM_EN_REGS; r++)
		begin
			if (reg_wr && (reg_addr == itbt_pkg::REG_EN0 + 4'(r)))
				next_s.en[r*8 +: 8] = reg_wdata;
			if (reg_rd && (reg_addr == itbt_pkg::REG_EN0 + 4'(r)))
				next_s.rdata = s.en[r*8 +: 8];
		end
		if (reg_rd && (reg_addr == itbt_pkg::REG_STATUS))
			next_s.rdata = {bus_req, 2'b00, s.set};
		// New events win over the service clear; disabled sources are dropped
		next_s.pend = (next_s.pend | (src_evt & s.en)) & next_s.en;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.st <= itbt_pkg::ITBT_IDLE;
		end
		else
			s <= next_s;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	bus_owner_a: assert property ((mem_rd || mem_wr) |-> bus_req)
		else $error("memory access without bus ownership");
	load_first_a: assert property ($rose(bus_req) |-> mem_rd && (mem_addr == set_base))
		else $error("activation did not start by loading its set");
	area_range_a: assert property (
		(s.st == itbt_pkg::ITBT_LOAD || s.st == itbt_pkg::ITBT_WB) && (mem_rd || mem_wr)
		|-> mem_addr >= itbt_pkg::CD_BASE && mem_addr <= itbt_pkg::CD_END)
		else $error("control data access outside its area");
	wb_after_a: assert property (
		$past(s.st) == itbt_pkg::ITBT_XWR && s.st == itbt_pkg::ITBT_WB
		|-> mem_wr ##1 mem_wr ##1 mem_wr ##1 mem_wr
		##1 mem_wr ##1 mem_wr ##1 mem_wr ##1 mem_wr)
		else $error("write-back not eight consecutive writes");
	blk_size_a: assert property (
		$past(s.st) == itbt_pkg::ITBT_LOAD && s.st == itbt_pkg::ITBT_XRD
		|-> s.bcnt == ((s.bls == 8'h00) ? itbt_pkg::BLOCK_256 : {1'b0, s.bls}))
		else $error("block length wrong after load");
	src_step_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && !rpt
		|=> s.sar == $past(s.sar) + {15'h0000, $past(s.ctl[itbt_pkg::CTL_SRC_STEP])})
		else $error("source pointer step wrong");
	dst_step_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && !rpt
		|=> s.dar == $past(s.dar) + {15'h0000, $past(s.ctl[itbt_pkg::CTL_DST_STEP])})
		else $error("destination pointer step wrong");
	reload_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && s.bcnt == 9'h001 && rpt && s.cct == 8'h01
		|=> s.cct == $past(s.rld))
		else $error("repeat count not reloaded");
	count_dec_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && s.bcnt == 9'h001 && s.cct != 8'h01
		|=> s.cct == $past(s.cct) - 8'h01)
		else $error("count not decremented once");
	// Eight write-back cycles and the closing cycle lie between last byte and pulse
	irq_norm_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && s.bcnt == 9'h001 && !rpt && s.cct == 8'h01
		&& !s.ctl[itbt_pkg::CTL_CHAIN] |-> ##10 cpu_irq)
		else $error("normal-mode end did not interrupt");
	irq_cause_a: assert property (
		cpu_irq |-> $past(s.st) == itbt_pkg::ITBT_DONE && $past(s.irq_req))
		else $error("interrupt without a qualifying end");
	stop_en_a: assert property (
		s.st == itbt_pkg::ITBT_DONE && s.stop_req && !reg_wr |=> !s.en[$past(s.src)])
		else $error("finished source still enabled");
	pend_mask_a: assert property ((s.pend & ~s.en) == '0)
		else $error("disabled source still pending");
	start_a: assert property (
		s.st == itbt_pkg::ITBT_IDLE && |(src_evt & s.en) && !reg_wr |=> |s.pend ##1 bus_req)
		else $error("enabled event did not start a transfer");
	rpt_quiet_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && s.bcnt == 9'h001 && rpt && s.cct == 8'h01
		&& !s.ctl[itbt_pkg::CTL_RPT_IRQ] && !s.irq_req |=> !s.irq_req && !s.stop_req)
		else $error("repeat end raised a request with its interrupt bit clear");
	area_walk_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && dst_is_area && !(s.bcnt == 9'h001 && s.cct == 8'h01)
		|=> s.dar == $past(s.dar) + 16'h0001)
		else $error("destination repeat area did not advance");
	src_rewind_a: assert property (
		s.st == itbt_pkg::ITBT_XWR && s.bcnt == 9'h001 && src_is_area && s.cct == 8'h01
		|=> s.sar == $past(s.sar) + 16'h0001 - {8'h00, $past(s.rld)} * {8'h00, $past(s.bls)})
		else $error("source repeat area not rewound");
	chain_next_a: assert property (
		s.st == itbt_pkg::ITBT_WB && s.cnt == itbt_pkg::CD_BYTES - 4'h1
		&& s.ctl[itbt_pkg::CTL_CHAIN] && s.set != itbt_pkg::LAST_SET
		|=> s.st == itbt_pkg::ITBT_LOAD && s.set == $past(s.set) + 5'h01 && bus_req)
		else $error("chained set not loaded before bus release");
	last_set_a: assert property (
		s.st == itbt_pkg::ITBT_WB && s.cnt == itbt_pkg::CD_BYTES - 4'h1
		&& s.set == itbt_pkg::LAST_SET |=> s.st == itbt_pkg::ITBT_DONE)
		else $error("last set chained onward");
endmodule // itbt_ctrl
`default_nettype wire

//--- itbt_pkg.sv
// Constants, register map and state encoding of the byte transfer controller
`default_nettype none
package itbt_pkg;
	localparam int NUM_SETS = 24;
	localparam int NUM_EN_REGS = 7;
	localparam int NUM_SRC = NUM_EN_REGS * 8;
	localparam logic [4:0] LAST_SET = 5'h17;
	// Control-data area in memory
	localparam logic [15:0] CD_BASE = 16'h2c40;
	localparam logic [15:0] CD_END = 16'h2cff;
	localparam logic [3:0] CD_BYTES = 4'h8;
	localparam logic [2:0] FLD_CTL = 3'h0;
	localparam logic [2:0] FLD_BLS = 3'h1;
	localparam logic [2:0] FLD_CCT = 3'h2;
	localparam logic [2:0] FLD_RLD = 3'h3;
	localparam logic [2:0] FLD_SAR_LO = 3'h4;
	localparam logic [2:0] FLD_SAR_HI = 3'h5;
	localparam logic [2:0] FLD_DAR_LO = 3'h6;
	localparam logic [2:0] FLD_DAR_HI = 3'h7;
	// transfer_control bit positions
	localparam int CTL_MODE = 0;
	localparam int CTL_RPT_SEL = 1;
	localparam int CTL_SRC_STEP = 2;
	localparam int CTL_DST_STEP = 3;
	localparam int CTL_CHAIN = 4;
	localparam int CTL_RPT_IRQ = 5;
	// Software register port
	localparam logic [3:0] REG_EN0 = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [8:0] BLOCK_256 = 9'h100;
	typedef enum logic [2:0] {
		ITBT_IDLE = 3'b000,
		ITBT_LOAD = 3'b001,
		ITBT_XRD  = 3'b011,
		ITBT_XCAP = 3'b010,
		ITBT_XWR  = 3'b110,
		ITBT_WB   = 3'b111,
		ITBT_DONE = 3'b101
	} itbt_state_t;
endpackage : itbt_pkg
`default_nettype wire

//--- itbt_mem.sv
// Byte memory on the shared bus: control data area, sources and destinations
`default_nettype none
module itbt_mem (
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	// Data valid one cycle only; an idle bus shows the inverse so stale reads show up
	always @(posedge clk)
	begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
	end
endmodule // itbt_mem
`default_nettype wire

//--- itbt_ctrl_tb.sv
// Self-checking bench for the byte transfer controller
`default_nettype none
module itbt_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		int set;
		logic [7:0] ctl, bls, cct, rld, ecct;
		logic [15:0] soff, doff, n;
		logic [1:0] inc;
		logic irq, en;
	} itbt_row_t;
	localparam logic [15:0] S = 16'h1000;
	localparam logic [15:0] D = 16'h3000;
	itbt_row_t rows [8] = '{
		'{0, 8'h0c, 8'h02, 8'h02, 8'h00, 8'h01, 16'h2, 16'h2, 16'h2, 2'h3, 1'b0, 1'b1},
		'{3, 8'h08, 8'h03, 8'h01, 8'h00, 8'h00, 16'h0, 16'h3, 16'h3, 2'h1, 1'b1, 1'b0},
		'{7, 8'h04, 8'h01, 8'h00, 8'h00, 8'hff, 16'h1, 16'h0, 16'h1, 2'h2, 1'b0, 1'b1},
		'{10, 8'h0c, 8'h00, 8'h05, 8'h00, 8'h04, 16'h100, 16'h100, 16'h100, 2'h3, 1'b0, 1'b1},
		'{12, 8'h05, 8'h02, 8'h01, 8'h04, 8'h04, 16'h2, 16'hfffa, 16'h2, 2'h3, 1'b0, 1'b1},
		'{16, 8'h23, 8'h01, 8'h01, 8'h03, 8'h03, 16'hfffe, 16'h0, 16'h1, 2'h2, 1'b1, 1'b0},
		'{20, 8'h01, 8'h02, 8'h03, 8'h09, 8'h02, 16'h0, 16'h2, 16'h2, 2'h1, 1'b0, 1'b1},
		'{23, 8'h26, 8'h02, 8'h01, 8'h00, 8'h00, 16'h2, 16'h0, 16'h2, 2'h2, 1'b1, 1'b0}
	};
	logic        clk, sys_rst, reg_wr, reg_rd, bus_req, mem_rd, mem_wr, cpu_irq, bq;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata, ld;
	logic [55:0] src_evt;
	logic [15:0] mem_addr, nw, ni, nb, la, b;
	logic [5:0]  cpu_irq_src, isrc;
	int          n_errors, checks;
	itbt_row_t   r;

	itbt_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_evt(src_evt),
		.bus_req(bus_req), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cpu_irq(cpu_irq),
		.cpu_irq_src(cpu_irq_src));
	itbt_mem mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	always #25 clk = ~clk;

	// Data writes outside the control area, interrupts and bus tenures
	always @(posedge clk)
	begin
		if (mem_wr && (mem_addr < itbt_pkg::CD_BASE || mem_addr > itbt_pkg::CD_END))
		begin
			nw++;
			la = mem_addr;
			ld = mem_wdata;
		end
		if (cpu_irq === 1'b1)
		begin
			ni++;
			isrc = cpu_irq_src;
		end
		if (bus_req && !bq)
			nb++;
		bq = bus_req;
	end

	function automatic logic [7:0] pat(logic [15:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	task automatic results;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask

	task automatic ld_set(int s, logic [7:0] c, logic [7:0] bl, logic [7:0] ct, logic [7:0] rl);
		b = itbt_pkg::CD_BASE + 16'(s * 8);
		mem_i.mem[b] = c;
		mem_i.mem[b + 16'h1] = bl;
		mem_i.mem[b + 16'h2] = ct;
		mem_i.mem[b + 16'h3] = rl;
		{mem_i.mem[b + 16'h5], mem_i.mem[b + 16'h4]} = S;
		{mem_i.mem[b + 16'h7], mem_i.mem[b + 16'h6]} = D;
	endtask

	// Returns at the edge that samples the one-cycle event
	task automatic go(int s);
		@(negedge clk);
		nw = 16'h0;
		ni = 16'h0;
		nb = 16'h0;
		@(posedge clk);
		src_evt <= 56'h1 << s;
		@(posedge clk);
		src_evt <= '0;
	endtask

	task automatic wait_done;
		bit seen = 1'b0;
		for (int k = 0; k < 3000; k++)
		begin
			@(negedge clk);
			if (seen && bus_req === 1'b0)
			begin
				repeat (3) @(negedge clk);
				return;
			end
			seen = seen | (bus_req === 1'b1);
		end
		n_errors++;
		$display("wrong value at %0t: activation never finished", $time);
		results;
	endtask

	initial
	begin
		{clk, reg_wr, reg_rd, bq, reg_addr, reg_wdata, src_evt} = '0;
		sys_rst = 1'b1;
		for (int a = 0; a < 512; a++)
			mem_i.mem[S + 16'(a)] = pat(S + 16'(a));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(4'h7, 8'h00);
		for (int i = 0; i < 7; i++)
			wr(4'(i), 8'h30 + 8'(i));
		wr(4'h8, 8'hff);
		for (int i = 0; i < 7; i++)
			rd(4'(i), 8'h30 + 8'(i));
		rd(4'h8, 8'h00);
		for (int i = 0; i < 7; i++)
			wr(4'(i), 8'h00);
		// Set 23 never chains, as software must guarantee
		foreach (rows[i])
		begin
			r = rows[i];
			ld_set(r.set, r.ctl, r.bls, r.cct, r.rld);
			wr(4'(r.set / 8), 8'h1 << (r.set % 8));
			go(r.set);
			wait_done;
			b = itbt_pkg::CD_BASE + 16'(r.set * 8);
			chk({8'h00, mem_i.mem[b + 16'h2]}, {8'h00, r.ecct});
			chk({mem_i.mem[b + 16'h5], mem_i.mem[b + 16'h4]}, S + r.soff);
			chk({mem_i.mem[b + 16'h7], mem_i.mem[b + 16'h6]}, D + r.doff);
			chk(nw, r.n);
			chk(la, D + (r.inc[0] ? r.n - 16'h1 : 16'h0));
			chk({8'h00, ld}, {8'h00, pat(S + (r.inc[1] ? r.n - 16'h1 : 16'h0))});
			chk(ni, {15'h0, r.irq});
			if (r.irq)
				chk({10'h0, isrc}, 16'(r.set));
			rd(4'(r.set / 8), r.en ? 8'h1 << (r.set % 8) : 8'h00);
		end
		// Chained pair must share one bus tenure
		ld_set(1, 8'h1c, 8'h01, 8'h04, 8'h00);
		ld_set(2, 8'h0c, 8'h01, 8'h04, 8'h00);
		wr(4'h0, 8'h02);
		go(1);
		@(negedge clk);
		chk({15'h0, bus_req}, 16'h0);
		@(negedge clk);
		chk({15'h0, bus_req}, 16'h1);
		rd(4'h7, 8'h81);
		wait_done;
		chk(nb, 16'h1);
		chk(nw, 16'h2);
		chk({8'h00, mem_i.mem[itbt_pkg::CD_BASE + 16'h12]}, 16'h3);
		// A cleared enable bit must silence its source
		wr(4'h0, 8'h00);
		go(1);
		repeat (8) @(negedge clk);
		chk(nb, 16'h0);
		// Reset in mid-activation must drop the bus and clear enable register 0
		wr(4'h0, 8'h02);
		go(1);
		repeat (4) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({15'h0, bus_req}, 16'h0);
		chk({10'h0, cpu_irq_src}, 16'h0);
		rd(4'h0, 8'h00);
		results;
	end
endmodule // itbt_ctrl_tb
`default_nettype wire
